// File: rtl/seg_seq_params.svh
// Register offsets, field positions, reset values and timing counts of the segment sequencer
`ifndef SEG_SEQ_PARAMS_SVH
`define SEG_SEQ_PARAMS_SVH
`define OFS_CONTROL 8'h00
`define OFS_CHAINING_MODE 8'h04
`define OFS_SPEED_SOURCE 8'h08
`define OFS_FIXED_SPEED 8'h0C
`define OFS_IDLE_TIME 8'h10
`define OFS_STATUS 8'h14
`define OFS_POS_ERROR 8'h18
`define OFS_FILT_ERROR 8'h1C
`define OFS_SEG_LENGTH 8'h20
`define TRIG_EDGE_BIT 0
`define SEL_INHIBIT_BIT 1
`define RST_CONTROL 16'h0000
`define RST_CHAINING 16'h0000
`define RST_SPEED_SRC 16'h0000
`define RST_FIXED_SPEED 16'h01F4
`define RST_IDLE_TIME 16'h0001
`define RST_SEG_LENGTH 32'h00002710
`define SPEED_SRC_MAX 16'h0004
`define IDLE_UNIT_NS 1000000
`define CLK_PERIOD_NS 25
`define IDLE_UNIT_CYCLES (`IDLE_UNIT_NS / `CLK_PERIOD_NS)
`define FILT_SHIFT 4
`endif

// File: rtl/seg_seq_pkg.sv
// Types shared by the segment sequencer
`default_nettype none
package seg_seq_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_RUN = 4'b0010,
        ST_DONE_WAIT = 4'b0100,
        ST_GAP = 4'b1000
    } seq_state_t;
    typedef struct packed {
        logic [15:0] analog_one;
        logic [15:0] analog_two;
        logic [15:0] analog_three;
        logic [15:0] pulse_rate;
    } speed_inputs_t;
    typedef struct packed {
        logic trigger;
        logic [3:0] select;
    } ctrl_inputs_t;
endpackage
`default_nettype wire

// File: rtl/seg_error_accum.sv
// Position error accumulators: raw and filtered speed command minus actual speed
`include "seg_seq_params.svh"
`default_nettype none
module seg_error_accum #(
    parameter int W = 32
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clear,
    input wire logic signed [15:0] speed_cmd,
    input wire logic signed [15:0] actual_speed,
    output logic signed [15:0] filt_cmd,
    output logic signed [W-1:0] pos_err,
    output logic signed [W-1:0] filt_err
);
    logic signed [15:0] filt_q;
    logic signed [16:0] step;

    // First order low-pass on the planned speed
    assign step = 17'(speed_cmd) - 17'(filt_q);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            filt_q <= 16'sh0000;
        end else begin
            filt_q <= filt_q + 16'(step >>> `FILT_SHIFT);
        end
    end
    assign filt_cmd = filt_q;

    // Raw error accumulation
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pos_err <= '0;
        end else if (clear) begin
            pos_err <= '0;
        end else begin
            pos_err <= pos_err + W'(speed_cmd) - W'(actual_speed); // see R8
        end
    end

    // Filtered error accumulation
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            filt_err <= '0;
        end else if (clear) begin
            filt_err <= '0;
        end else begin
            filt_err <= filt_err + W'(filt_q) - W'(actual_speed); // see R9
        end
    end
endmodule
`default_nettype wire

// File: rtl/seg_sequencer.sv
// Multi-segment position sequencer with AXI4-Lite register access
// How it works
// R1: Edge mode bit set: trigger rising edge starts run, which continues after release.
// R2: Edge mode bit clear: trigger is a level; run stops when it drops.
// R3: Inhibit clear with select inputs in use: select change starts the new segment. Code: only in ST_IDLE, and with the trigger high in level mode.
// R4: Inhibit set: select changes ignored; controller must re-trigger to start.
// R5: Chaining 0: wait completion, then idle time, then issue next segment.
// R6: Chaining 1: idle wait starts on issue; next segment issued without completion.
// R7: Speed source 0..4: fixed, analog one/two/three, pulse rate; three unsupported.
// R8: Position error accumulates planned speed minus actual speed.
// R9: Filtered error accumulates filtered speed command minus actual speed.
`include "seg_seq_params.svh"
`default_nettype none
module seg_sequencer #(
    parameter int IDLE_UNIT_CYC = `IDLE_UNIT_CYCLES,
    parameter int ERR_W = 32
) (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire seg_seq_pkg::ctrl_inputs_t CTRL_IN,
    input wire seg_seq_pkg::speed_inputs_t SPEED_IN,
    input wire logic signed [15:0] ACTUAL_SPEED,
    input wire logic [31:0] ACTUAL_POS_DONE,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic SEG_RUNNING,
    output logic SEG_ISSUE,
    output logic [3:0] SEG_INDEX,
    output logic signed [15:0] SEG_SPEED_CMD
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    seg_seq_pkg::seq_state_t state_q;
    logic [15:0] control_q, chaining_q, speed_src_q, fixed_speed_q, idle_time_q;
    logic [31:0] seg_len_q, out_cnt_q;
    logic trig_m_q, trig_s_q, trig_old_q;
    logic [3:0] sel_m_q, sel_s_q, sel_old_q;
    logic [31:0] gap_cnt_q;
    logic gap_armed_q;
    logic aw_hold_q, w_hold_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic signed [15:0] speed_sel;
    logic signed [ERR_W-1:0] pos_err, filt_err;
    logic trig_rise, sel_change, start, stop, seg_done, gap_over, wr_go;
    logic [31:0] gap_len;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Two flops on the pins from the external controller
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            trig_m_q <= 1'b0;
            trig_s_q <= 1'b0;
            trig_old_q <= 1'b0;
            sel_m_q <= 4'h0;
            sel_s_q <= 4'h0;
            sel_old_q <= 4'h0;
        end else begin
            trig_m_q <= CTRL_IN.trigger;
            trig_s_q <= trig_m_q;
            trig_old_q <= trig_s_q;
            sel_m_q <= CTRL_IN.select;
            sel_s_q <= sel_m_q;
            sel_old_q <= sel_s_q;
        end
    end

    // Start and stop conditions
    assign trig_rise = trig_s_q && !trig_old_q;
    assign sel_change = (sel_s_q != sel_old_q) && !control_q[`SEL_INHIBIT_BIT]; // see R3, R4
    assign start = trig_rise || sel_change; // see R4
    assign stop = !control_q[`TRIG_EDGE_BIT] && !trig_s_q; // see R1, R2

    // ------------------------------------------------------------
    // Speed source select
    // ------------------------------------------------------------
    always_comb begin
        case (speed_src_q[2:0]) // see R7
            3'h0: speed_sel = fixed_speed_q;
            3'h1: speed_sel = SPEED_IN.analog_one;
            3'h2: speed_sel = SPEED_IN.analog_two;
            3'h3: speed_sel = 16'sh0000; // Third analog input not fitted
            3'h4: speed_sel = SPEED_IN.pulse_rate;
            default: speed_sel = 16'sh0000;
        endcase
    end

    // ------------------------------------------------------------
    // Segment sequencer
    // ------------------------------------------------------------
    assign seg_done = out_cnt_q >= seg_len_q;
    assign gap_len = 32'(idle_time_q) * 32'(IDLE_UNIT_CYC);
    assign gap_over = gap_armed_q && (gap_cnt_q >= gap_len);

    // Sequence state and output progress
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= seg_seq_pkg::ST_IDLE;
            out_cnt_q <= 32'h00000000;
            SEG_ISSUE <= 1'b0;
            SEG_INDEX <= 4'h0;
        end else begin
            SEG_ISSUE <= 1'b0;
            case (state_q)
                seg_seq_pkg::ST_IDLE: begin
                    if (start && !(stop && !trig_rise)) begin
                        state_q <= seg_seq_pkg::ST_RUN;
                        out_cnt_q <= 32'h00000000;
                        SEG_ISSUE <= 1'b1;
                        SEG_INDEX <= sel_s_q;
                    end
                end
                seg_seq_pkg::ST_RUN: begin
                    out_cnt_q <= out_cnt_q + 32'h00000001;
                    if (stop) begin
                        state_q <= seg_seq_pkg::ST_IDLE; // see R2
                    end else if (chaining_q[0]) begin
                        if (gap_over) begin // see R6
                            out_cnt_q <= 32'h00000000;
                            SEG_ISSUE <= 1'b1;
                            SEG_INDEX <= SEG_INDEX + 4'h1;
                        end
                    end else if (seg_done) begin
                        state_q <= seg_seq_pkg::ST_GAP; // see R5
                    end
                end
                seg_seq_pkg::ST_GAP: begin
                    if (stop) begin
                        state_q <= seg_seq_pkg::ST_IDLE;
                    end else if (gap_over) begin // see R5
                        state_q <= seg_seq_pkg::ST_RUN;
                        out_cnt_q <= 32'h00000000;
                        SEG_ISSUE <= 1'b1;
                        SEG_INDEX <= SEG_INDEX + 4'h1;
                    end
                end
                default: state_q <= seg_seq_pkg::ST_IDLE;
            endcase
        end
    end

    // Idle gap timer: armed at issue for mode 1, at completion for mode 0
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            gap_cnt_q <= 32'h00000000;
            gap_armed_q <= 1'b0;
        end else if ((SEG_ISSUE || (state_q == seg_seq_pkg::ST_RUN && !gap_armed_q))
                && chaining_q[0]) begin
            gap_cnt_q <= 32'h00000001; // see R6
            gap_armed_q <= 1'b1;
        end else if (state_q == seg_seq_pkg::ST_RUN && seg_done && !chaining_q[0]) begin
            gap_cnt_q <= 32'h00000001; // see R5
            gap_armed_q <= 1'b1;
        end else if (gap_over || state_q == seg_seq_pkg::ST_IDLE) begin
            gap_armed_q <= 1'b0;
        end else if (gap_armed_q) begin
            gap_cnt_q <= gap_cnt_q + 32'h00000001;
        end
    end

    // Registered status outputs
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            SEG_RUNNING <= 1'b0;
            SEG_SPEED_CMD <= 16'sh0000;
        end else begin
            SEG_RUNNING <= state_q != seg_seq_pkg::ST_IDLE; // see R1
            SEG_SPEED_CMD <= (state_q == seg_seq_pkg::ST_RUN) ? speed_sel : 16'sh0000;
        end
    end

    // Error accumulators
    seg_error_accum #(
        .W(ERR_W)
    ) u_err (
        .clk(MCLK),
        .rst_b(RST_B),
        .clear(SEG_ISSUE),
        .speed_cmd(SEG_SPEED_CMD),
        .actual_speed(ACTUAL_SPEED),
        .filt_cmd(),
        .pos_err(pos_err),
        .filt_err(filt_err)
    );

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    assign wr_go = aw_hold_q && w_hold_q && !S_AXI_BVALID;

    // Write channel capture and response
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= 2'h0;
        end else begin
            S_AXI_AWREADY <= !aw_hold_q && !S_AXI_AWREADY && S_AXI_AWVALID;
            S_AXI_WREADY <= !w_hold_q && !S_AXI_WREADY && S_AXI_WVALID;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_hold_q <= 1'b1;
                w_data_q <= S_AXI_WDATA;
                w_strb_q <= S_AXI_WSTRB;
            end
            if (wr_go) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                case (aw_addr_q)
                    `OFS_CONTROL, `OFS_CHAINING_MODE, `OFS_SPEED_SOURCE, `OFS_FIXED_SPEED,
                    `OFS_IDLE_TIME, `OFS_SEG_LENGTH: S_AXI_BRESP <= 2'h0;
                    default: S_AXI_BRESP <= 2'h2;
                endcase
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // Configuration registers, written whole only when byte lane 0 is strobed
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            control_q <= `RST_CONTROL;
            chaining_q <= `RST_CHAINING;
            speed_src_q <= `RST_SPEED_SRC;
            fixed_speed_q <= `RST_FIXED_SPEED;
            idle_time_q <= `RST_IDLE_TIME;
            seg_len_q <= `RST_SEG_LENGTH;
        end else if (wr_go && w_strb_q[0]) begin
            case (aw_addr_q)
                `OFS_CONTROL: control_q <= {14'h0, w_data_q[1:0]};
                `OFS_CHAINING_MODE: chaining_q <= {15'h0, w_data_q[0]};
                `OFS_SPEED_SOURCE: begin
                    if (w_data_q[15:0] <= `SPEED_SRC_MAX) begin // see R7
                        speed_src_q <= w_data_q[15:0];
                    end
                end
                `OFS_FIXED_SPEED: fixed_speed_q <= w_data_q[15:0];
                `OFS_IDLE_TIME: idle_time_q <= w_data_q[15:0];
                `OFS_SEG_LENGTH: seg_len_q <= w_data_q;
                default: control_q <= control_q;
            endcase
        end
    end

    // Read channel
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= 2'h0;
        end else begin
            S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= 2'h0;
                case (S_AXI_ARADDR)
                    `OFS_CONTROL: S_AXI_RDATA <= {16'h0000, control_q};
                    `OFS_CHAINING_MODE: S_AXI_RDATA <= {16'h0000, chaining_q};
                    `OFS_SPEED_SOURCE: S_AXI_RDATA <= {16'h0000, speed_src_q};
                    `OFS_FIXED_SPEED: S_AXI_RDATA <= {16'h0000, fixed_speed_q};
                    `OFS_IDLE_TIME: S_AXI_RDATA <= {16'h0000, idle_time_q};
                    `OFS_STATUS: S_AXI_RDATA <= {23'h0, SEG_INDEX, state_q, SEG_RUNNING};
                    `OFS_POS_ERROR: S_AXI_RDATA <= 32'(pos_err);
                    `OFS_FILT_ERROR: S_AXI_RDATA <= 32'(filt_err);
                    `OFS_SEG_LENGTH: S_AXI_RDATA <= seg_len_q;
                    default: begin
                        S_AXI_RDATA <= 32'h00000000;
                        S_AXI_RRESP <= 2'h2;
                    end
                endcase
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// File: sim/seq_ctrl_model.sv
// Outside controller model that drives the trigger and select pins
`default_nettype none
module seq_ctrl_model (
    input wire logic clk,
    output seg_seq_pkg::ctrl_inputs_t ctrl
);
    timeunit 1ns;
    timeprecision 100ps;
    // Pins idle low until commanded
    initial ctrl = '0;
    // Level on the trigger pin, changed just after an edge
    task automatic set_trig(input logic v);
        @(posedge clk);
        ctrl.trigger <= v;
    endtask
    // New segment number on the select pins
    task automatic set_sel(input logic [3:0] v);
        @(posedge clk);
        ctrl.select <= v;
    endtask
    // Trigger re-asserted for n cycles to start a run
    task automatic retrig(input int n);
        set_trig(1'b1);
        repeat (n) @(posedge clk);
        ctrl.trigger <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: sim/seq_monitor.sv
// Port checks for the segment sequencer
`default_nettype none
module seq_monitor (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire seg_seq_pkg::ctrl_inputs_t CTRL_IN,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic SEG_RUNNING,
    input wire logic SEG_ISSUE
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    // Handshake steps
    sequence wr_taken;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence rd_taken;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    chk_issue_pulse: assert property (SEG_ISSUE |=> !SEG_ISSUE)
        else $error("issue pulse too long");
    chk_run_after_issue: assert property (SEG_ISSUE |-> ##2 SEG_RUNNING)
        else $error("not running after issue");
    chk_trig_start: assert property (
        $rose(CTRL_IN.trigger) && !SEG_RUNNING && !SEG_ISSUE |-> ##[1:6] SEG_ISSUE)
        else $error("trigger did not start a segment");
    chk_write_answer: assert property (wr_taken |-> ##2 S_AXI_BVALID)
        else $error("late write response");
    chk_read_answer: assert property (rd_taken |=> S_AXI_RVALID)
        else $error("late read data");
    chk_bresp_hold: assert property (
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped");
    chk_rdata_hold: assert property (
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped");
    chk_unmapped_rd: assert property (
        rd_taken ##0 (S_AXI_ARADDR > 8'h20) |=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0)
        else $error("unmapped read not refused");
endmodule
bind seg_sequencer seq_monitor u_mon (.MCLK(MCLK), .RST_B(RST_B), .CTRL_IN(CTRL_IN),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .SEG_RUNNING(SEG_RUNNING), .SEG_ISSUE(SEG_ISSUE));
`default_nettype wire

// File: sim/multi_segment_position_sequencer_tb_top.sv
// Register and sequencing tests for the segment sequencer
`include "seg_seq_params.svh"
`default_nettype none
module multi_segment_position_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
    logic [31:0] w_data = 32'h0, r_data, d, p, f;
    logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
    logic aw_ready, w_ready, b_valid, ar_ready, r_valid, running, issue;
    logic [1:0] b_resp, r_resp;
    logic [3:0] w_strb = 4'hF;
    logic [3:0] index;
    logic signed [15:0] act = 16'h0000, spd;
    logic [15:0] exp_spd [5] = '{`RST_FIXED_SPEED, 16'h0011, 16'h0022, 16'h0000, 16'h0044};
    seg_seq_pkg::ctrl_inputs_t ctrl;
    seg_seq_pkg::speed_inputs_t sp = '{16'h0011, 16'h0022, 16'h0033, 16'h0044};
    int errors = 0, n_tests = 0, cyc = 0, last_iss = 0, gap = 0, n_iss = 0, b;
    // Clock at 40 MHz
    always #12.5 mclk = ~mclk;
    seq_ctrl_model u_ctrl (.clk(mclk), .ctrl(ctrl));
    seg_sequencer #(.IDLE_UNIT_CYC(4)) dut (.MCLK(mclk), .RST_B(rst_b), .CTRL_IN(ctrl),
        .SPEED_IN(sp), .ACTUAL_SPEED(act), .ACTUAL_POS_DONE(32'h0), .S_AXI_AWADDR(aw_addr),
        .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(aw_ready), .S_AXI_WDATA(w_data),
        .S_AXI_WSTRB(w_strb), .S_AXI_WVALID(w_valid), .S_AXI_WREADY(w_ready),
        .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready),
        .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready),
        .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid),
        .S_AXI_RREADY(r_ready), .SEG_RUNNING(running), .SEG_ISSUE(issue),
        .SEG_INDEX(index), .SEG_SPEED_CMD(spd));
    // Spacing between issue pulses
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (issue === 1'b1) begin
            gap <= cyc - last_iss;
            last_iss <= cyc;
            n_iss <= n_iss + 1;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
    endtask
    // Write with both channels offered together, response ready raised in the same cycle as the response
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        aw_addr <= a;
        w_data <= v;
        aw_valid <= 1'b1;
        w_valid <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge mclk);
            if (!ad && aw_ready) begin
                ad = 1'b1;
                aw_valid <= 1'b0;
            end
            if (!dd && w_ready) begin
                dd = 1'b1;
                w_valid <= 1'b0;
            end
        end
        @(posedge mclk);
        b_ready <= 1'b1;
        do @(posedge mclk); while (b_valid !== 1'b1);
        b_ready <= 1'b0;
        chk(b_resp, er);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
        ar_addr <= a;
        ar_valid <= 1'b1;
        do @(posedge mclk); while (ar_ready !== 1'b1);
        ar_valid <= 1'b0;
        @(posedge mclk);
        r_ready <= 1'b1;
        do @(posedge mclk); while (r_valid !== 1'b1);
        r_ready <= 1'b0;
        v = r_data;
        chk(r_resp, er);
    endtask
    task automatic wait_iss(input int k);
        for (int i = 0; i < 600 && n_iss < k; i++) @(posedge mclk);
    endtask
    // Hang guard
    initial begin
        repeat (30000) @(posedge mclk);
        errors++;
        finish_test();
    end
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        do_reset();
        rd(`OFS_CHAINING_MODE, d, 2'h0); chk(d, 32'h0);
        rd(`OFS_SPEED_SOURCE, d, 2'h0); chk(d, 32'h0);
        rd(`OFS_FIXED_SPEED, d, 2'h0); chk(d, {16'h0, `RST_FIXED_SPEED});
        rd(8'h40, d, 2'h2); chk(d, 32'h0);
        wr(`OFS_STATUS, 32'h1, 2'h2);
        w_strb <= 4'hE;
        wr(`OFS_FIXED_SPEED, 32'h1234, 2'h0);
        w_strb <= 4'hF;
        rd(`OFS_FIXED_SPEED, d, 2'h0); chk(d, {16'h0, `RST_FIXED_SPEED});
        $display("register test done");
        wr(`OFS_SEG_LENGTH, 32'h14, 2'h0);
        wr(`OFS_IDLE_TIME, 32'h2, 2'h0);
        wr(`OFS_CONTROL, 32'h1, 2'h0);
        u_ctrl.retrig(4);
        b = n_iss;
        wait_iss(b + 3);
        chk(running, 1'b1);
        chk(gap >= 28 && gap <= 30, 1'b1);
        wr(`OFS_CHAINING_MODE, 32'h1, 2'h0);
        wait_iss(n_iss + 3);
        chk(gap >= 8 && gap <= 10, 1'b1);
        do_reset();
        $display("chaining test done");
        u_ctrl.set_trig(1'b1);
        wait_iss(n_iss + 1);
        rd(`OFS_FILT_ERROR, f, 2'h0);
        rd(`OFS_POS_ERROR, p, 2'h0);
        chk($signed(f) < $signed(p), 1'b1);
        act <= 16'sh01F4;
        repeat (4) @(posedge mclk);
        rd(`OFS_POS_ERROR, p, 2'h0);
        rd(`OFS_POS_ERROR, d, 2'h0);
        chk(d, p);
        sp.analog_three <= 16'h0055;
        for (int s = 0; s < 5; s++) begin
            wr(`OFS_SPEED_SOURCE, s, 2'h0);
            repeat (4) @(posedge mclk);
            chk(spd, exp_spd[s]);
        end
        rd(`OFS_POS_ERROR, d, 2'h0);
        chk($signed(d) < $signed(p), 1'b1);
        wr(`OFS_SPEED_SOURCE, 32'h5, 2'h0);
        rd(`OFS_SPEED_SOURCE, d, 2'h0); chk(d, 32'h4);
        u_ctrl.set_trig(1'b0);
        repeat (8) @(posedge mclk);
        chk(running, 1'b0);
        $display("level and speed test done");
        wr(`OFS_CONTROL, 32'h1, 2'h0);
        u_ctrl.set_sel(4'h5);
        wait_iss(n_iss + 1);
        chk(index, 4'h5);
        do_reset();
        wr(`OFS_CONTROL, 32'h3, 2'h0);
        b = n_iss;
        u_ctrl.set_sel(4'h9);
        repeat (12) @(posedge mclk);
        chk(n_iss, b);
        u_ctrl.retrig(4);
        wait_iss(b + 1);
        chk(index, 4'h9);
        $display("select test done");
        finish_test();
    end
endmodule
`default_nettype wire
